// File: core/pmc_pkg.sv
`default_nettype none
package pmc_pkg;
    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CABLE_DIAG_CONTROL_OFS      = 8'h1e;
    localparam logic [7:0] PHY_RESET_CONTROL_OFS       = 8'h1f;
    localparam logic [7:0] LED_FUNCTION_CONTROL_OFS    = 8'h25;
    localparam logic [7:0] COMPLIANCE_TEST_CONTROL_OFS = 8'h27;
    localparam logic [7:0] BASIC_MODE_OFS              = 8'h01;
    localparam logic [7:0] SELF_TEST_ONE_OFS           = 8'h1b;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int           DIAG_START_BIT    = 15;
    localparam int           DIAG_DONE_BIT     = 1;
    localparam int           DIAG_FAIL_BIT     = 0;
    localparam logic [15:0]  DIAG_RSVD_VAL     = 16'h0100;
    localparam int           SW_RESET_BIT      = 15;
    localparam int           DIG_RESTART_BIT   = 14;
    localparam int           LED_POL_BIT       = 9;
    localparam int           LED_FUNC_LSB      = 3;
    localparam int           LED_ROUTE_LSB     = 0;
    localparam int           TEST_EN_BIT       = 4;
    localparam int           SELF_TEST_LOCK_BIT = 15;
    localparam logic [15:0]  LED_CTRL_RST      = 16'h0000;
    localparam logic [15:0]  TEST_CTRL_RST     = 16'h0000;
    localparam logic [15:0]  RESET_CTRL_RST    = 16'h0000;
    localparam logic         DIAG_DONE_RST     = 1'b1;
    localparam logic         DIAG_FAIL_RST     = 1'b0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int           CLK_PERIOD_NS     = 10;
    localparam int           RESTART_NS        = 100;
    localparam int           RESTART_CYC       = (RESTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        LED_LINK_OK    = 4'h0, LED_ACT       = 4'h1, LED_TX_ACT   = 4'h2,
        LED_RX_ACT     = 4'h3, LED_COL       = 4'h4, LED_SPD_100  = 4'h5,
        LED_SPD_10     = 4'h6, LED_FDX       = 4'h7, LED_LINK_BLK = 4'h8,
        LED_STRETCH    = 4'h9, LED_MII_LINK  = 4'ha, LED_LPI      = 4'hb,
        LED_MII_ERR    = 4'hc, LED_LINK_LOST = 4'hd, LED_PRBS_ERR = 4'he,
        LED_RSVD       = 4'hf
    } pmc_led_func_e;

    localparam logic [1:0] ROUTE_COL  = 2'h0;
    localparam logic [1:0] ROUTE_LED0 = 2'h3;

    typedef enum logic [1:0] {
        DIAG_IDLE = 2'b00,
        DIAG_RUN  = 2'b01
    } pmc_diag_state_e;

    // Status of the PHY that the LED can show
    typedef struct packed {
        logic link_ok;
        logic tx_act;
        logic rx_act;
        logic collision;
        logic speed_100;
        logic full_duplex;
        logic stretch_act;
        logic lpi;
        logic mii_err;
        logic blink;
        logic prbs_err;
    } pmc_phy_status_s;

    // Management register bus
    typedef struct packed {
        logic [7:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } pmc_bus_s;
endpackage
`default_nettype wire

// File: core/pmc_regs.sv
`default_nettype none
module pmc_regs (
    input  wire logic                     mclk_i,        // Core clock
    input  wire logic                     rst_n_i,       // Sync reset, low
    input  wire pmc_pkg::pmc_bus_s        bus_i,         // Management access
    output logic      [15:0]              rdata_o,       // Read data
    input  wire logic                     strap_pu_i,    // LED strap pulled up
    input  wire pmc_pkg::pmc_phy_status_s status_i,      // PHY status
    input  wire logic                     diag_done_i,   // Measurement complete pulse
    input  wire logic                     diag_fail_i,   // Measurement failed, with done
    output logic                          diag_run_o,    // Measurement running
    output logic                          phy_reset_o,   // Full PHY reset pulse
    output logic                          dig_restart_o, // Digital restart pulse
    output logic                          test_en_o,     // 10Base-Te patterns on
    output logic      [3:0]               test_sel_o,    // Test pattern select
    output logic                          col_led_o,     // LED on collision pin
    output logic                          led0_o         // LED on first LED pin
);
    import pmc_pkg::*;

    // ------------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------------
    function automatic logic hit(input pmc_bus_s b, input logic [7:0] ofs);
        hit = b.addr == ofs;
    endfunction

    logic wr_diag;
    logic wr_rst;
    logic wr_led;
    logic wr_test;
    logic rd_basic;
    logic wr_self_test;
    logic soft_rst;

    assign wr_diag      = bus_i.wr && hit(bus_i, CABLE_DIAG_CONTROL_OFS);
    assign wr_rst       = bus_i.wr && hit(bus_i, PHY_RESET_CONTROL_OFS);
    assign wr_led       = bus_i.wr && hit(bus_i, LED_FUNCTION_CONTROL_OFS);
    assign wr_test      = bus_i.wr && hit(bus_i, COMPLIANCE_TEST_CONTROL_OFS);
    assign rd_basic     = bus_i.rd && hit(bus_i, BASIC_MODE_OFS);
    assign wr_self_test = bus_i.wr && hit(bus_i, SELF_TEST_ONE_OFS)
                          && bus_i.wdata[SELF_TEST_LOCK_BIT];

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    pmc_diag_state_e diag_state_reg, diag_state_next;
    logic        done_reg, done_next;
    logic        fail_reg, fail_next;
    logic [15:0] rstc_reg, rstc_next;
    logic [15:0] led_reg, led_next;
    logic [15:0] test_reg, test_next;
    logic        strap_seen_reg, strap_seen_next;
    logic        lost_reg, lost_next;
    logic        link_prev_reg, link_prev_next;
    logic        prbs_reg, prbs_next;
    logic [15:0] rdata_reg, rdata_next;
    logic        col_reg, col_next;
    logic        led0_reg, led0_next;
    logic        ind;
    logic        drive;

    // Full software reset acts like the reset pin on all registers except the reset and restart pulse flops
    assign soft_rst = rstc_reg[SW_RESET_BIT];

    always_comb begin
        diag_state_next = diag_state_reg;
        done_next       = done_reg;
        fail_next       = fail_reg;
        rstc_next       = rstc_reg;
        led_next        = led_reg;
        test_next       = test_reg;
        strap_seen_next = 1'b1;
        lost_next       = lost_reg;
        link_prev_next  = status_i.link_ok;
        prbs_next       = prbs_reg;
        // Cable diagnostic handshake
        case (diag_state_reg)
            DIAG_IDLE: begin
                if (wr_diag && bus_i.wdata[DIAG_START_BIT]) begin
                    diag_state_next = DIAG_RUN;
                    done_next       = 1'b0;
                    fail_next       = 1'b0;
                end
            end
            DIAG_RUN: begin
                if (diag_done_i) begin
                    diag_state_next = DIAG_IDLE;
                    done_next       = 1'b1;
                    fail_next       = diag_fail_i;
                end else if (wr_diag && !bus_i.wdata[DIAG_START_BIT]) begin
                    diag_state_next = DIAG_IDLE;
                end
            end
            default: diag_state_next = DIAG_IDLE;
        endcase
        // Self-clearing reset bits, reserved bits kept as written
        rstc_next = {2'b00, rstc_reg[13:0]};
        if (wr_rst) begin
            rstc_next = bus_i.wdata;
        end
        if (wr_led) begin
            led_next = bus_i.wdata;
        end
        if (!strap_seen_reg) begin
            led_next[LED_POL_BIT] = !strap_pu_i;
        end
        if (wr_test) begin
            test_next = bus_i.wdata;
        end
        // Latched indications: new event wins over the clear
        if (rd_basic) begin
            lost_next = 1'b0;
        end
        if (link_prev_reg && !status_i.link_ok) begin
            lost_next = 1'b1;
        end
        if (wr_self_test) begin
            prbs_next = 1'b0;
        end
        if (status_i.prbs_err) begin
            prbs_next = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        rdata_next = 16'h0000;
        if (bus_i.rd) begin
            case (bus_i.addr)
                CABLE_DIAG_CONTROL_OFS: begin
                    rdata_next = DIAG_RSVD_VAL;
                    rdata_next[DIAG_START_BIT] = diag_state_reg == DIAG_RUN;
                    rdata_next[DIAG_DONE_BIT]  = done_reg;
                    rdata_next[DIAG_FAIL_BIT]  = fail_reg;
                end
                PHY_RESET_CONTROL_OFS:       rdata_next = rstc_reg;
                LED_FUNCTION_CONTROL_OFS:    rdata_next = led_reg;
                COMPLIANCE_TEST_CONTROL_OFS: rdata_next = test_reg;
                default:                     rdata_next = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // LED selection, polarity, routing
    // ------------------------------------------------------------------
    always_comb begin
        case (pmc_led_func_e'(led_reg[LED_FUNC_LSB +: 4]))
            LED_LINK_OK:   ind = status_i.link_ok;
            LED_ACT:       ind = status_i.tx_act | status_i.rx_act;
            LED_TX_ACT:    ind = status_i.tx_act;
            LED_RX_ACT:    ind = status_i.rx_act;
            LED_COL:       ind = status_i.collision;
            LED_SPD_100:   ind = status_i.speed_100;
            LED_SPD_10:    ind = !status_i.speed_100;
            LED_FDX:       ind = status_i.full_duplex;
            LED_LINK_BLK:  ind = status_i.link_ok &&
                                 !((status_i.tx_act | status_i.rx_act) && status_i.blink);
            LED_STRETCH:   ind = status_i.stretch_act;
            LED_MII_LINK:  ind = status_i.link_ok && status_i.speed_100
                                 && status_i.full_duplex;
            LED_LPI:       ind = status_i.lpi;
            LED_MII_ERR:   ind = status_i.mii_err;
            LED_LINK_LOST: ind = lost_reg;
            LED_PRBS_ERR:  ind = prbs_reg;
            default:       ind = 1'b0;
        endcase
        // Polarity bit set means active high
        drive = led_reg[LED_POL_BIT] ? ind : !ind;
        col_next  = !led_reg[LED_POL_BIT];
        led0_next = !led_reg[LED_POL_BIT];
        case (led_reg[LED_ROUTE_LSB +: 2])
            ROUTE_COL:  col_next  = drive;
            ROUTE_LED0: led0_next = drive;
            default: begin
                col_next  = !led_reg[LED_POL_BIT];
                led0_next = !led_reg[LED_POL_BIT];
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers; digital restart leaves configuration alone
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i || soft_rst) begin
            diag_state_reg <= DIAG_IDLE;
            done_reg       <= DIAG_DONE_RST;
            fail_reg       <= DIAG_FAIL_RST;
            rstc_reg       <= RESET_CTRL_RST;
            led_reg        <= LED_CTRL_RST;
            test_reg       <= TEST_CTRL_RST;
            strap_seen_reg <= 1'b0;
            lost_reg       <= 1'b0;
            link_prev_reg  <= 1'b0;
            prbs_reg       <= 1'b0;
            rdata_reg      <= 16'h0000;
            col_reg        <= 1'b0;
            led0_reg       <= 1'b0;
        end else begin
            diag_state_reg <= diag_state_next;
            done_reg       <= done_next;
            fail_reg       <= fail_next;
            rstc_reg       <= rstc_next;
            led_reg        <= led_next;
            test_reg       <= test_next;
            strap_seen_reg <= strap_seen_next;
            lost_reg       <= rstc_reg[DIG_RESTART_BIT] ? 1'b0 : lost_next;
            link_prev_reg  <= link_prev_next;
            prbs_reg       <= rstc_reg[DIG_RESTART_BIT] ? 1'b0 : prbs_next;
            rdata_reg      <= rdata_next;
            col_reg        <= col_next;
            led0_reg       <= led0_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    logic phy_reset_reg;
    logic dig_restart_reg;
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            phy_reset_reg   <= 1'b0;
            dig_restart_reg <= 1'b0;
        end else begin
            phy_reset_reg   <= soft_rst;
            dig_restart_reg <= rstc_reg[DIG_RESTART_BIT];
        end
    end

    assign rdata_o       = rdata_reg;
    // Only the running state has bit 0 set, so the pin is a plain flop bit
    assign diag_run_o    = diag_state_reg[0];
    assign phy_reset_o   = phy_reset_reg;
    assign dig_restart_o = dig_restart_reg;
    assign test_en_o     = test_reg[TEST_EN_BIT];
    assign test_sel_o    = test_reg[3:0];
    assign col_led_o     = col_reg;
    assign led0_o        = led0_reg;
endmodule
`default_nettype wire

// File: verif/pmc_regs_props.sv
`default_nettype none
module pmc_regs_props (
    input wire logic                     mclk_i,        // Core clock
    input wire logic                     rst_n_i,       // Sync reset, low
    input wire pmc_pkg::pmc_bus_s        bus_i,         // Management access
    input wire logic      [15:0]         rdata_o,       // Read data
    input wire logic                     strap_pu_i,    // LED strap
    input wire pmc_pkg::pmc_phy_status_s status_i,      // PHY status
    input wire logic                     diag_done_i,   // Measurement done
    input wire logic                     diag_fail_i,   // Measurement failed
    input wire logic                     diag_run_o,    // Measurement running
    input wire logic                     phy_reset_o,   // Full reset pulse
    input wire logic                     dig_restart_o, // Restart pulse
    input wire logic                     test_en_o,     // Test patterns on
    input wire logic      [3:0]          test_sel_o,    // Test pattern select
    input wire logic                     col_led_o,     // Collision pin LED
    input wire logic                     led0_o         // First LED pin
);
    import pmc_pkg::*;
    // ------------------------------------------------------------------
    // Decoded accesses
    // ------------------------------------------------------------------
    logic wr_diag;
    logic wr_rst;
    logic wr_test;
    logic wr_led;
    logic rd_led;
    logic pol_w;
    logic [1:0] route_w;
    logic mapped;
    assign wr_led  = bus_i.wr && (bus_i.addr == LED_FUNCTION_CONTROL_OFS);
    assign rd_led  = bus_i.rd && (bus_i.addr == LED_FUNCTION_CONTROL_OFS);
    assign pol_w   = bus_i.wdata[LED_POL_BIT];
    assign route_w = bus_i.wdata[1:0];
    assign wr_diag = bus_i.wr && (bus_i.addr == CABLE_DIAG_CONTROL_OFS);
    assign wr_rst  = bus_i.wr && (bus_i.addr == PHY_RESET_CONTROL_OFS);
    assign wr_test = bus_i.wr && (bus_i.addr == COMPLIANCE_TEST_CONTROL_OFS);
    assign mapped  = bus_i.addr inside {CABLE_DIAG_CONTROL_OFS, PHY_RESET_CONTROL_OFS,
        LED_FUNCTION_CONTROL_OFS, COMPLIANCE_TEST_CONTROL_OFS, BASIC_MODE_OFS};
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    AST_START_RUN: assert property (wr_diag && bus_i.wdata[15] |=> diag_run_o)
        else $error("start write did not launch measurement");
    AST_RUN_CAUSE: assert property ($rose(diag_run_o) |-> $past(wr_diag))
        else $error("measurement started without a start write");
    AST_DONE_CLEARS: assert property (diag_run_o && diag_done_i |=> !diag_run_o)
        else $error("start bit stayed set after done");
    AST_READ_DIAG: assert property (bus_i.rd && bus_i.addr == CABLE_DIAG_CONTROL_OFS |=>
        rdata_o[15] == $past(diag_run_o) && rdata_o[14:2] == DIAG_RSVD_VAL[14:2])
        else $error("diagnostic readback wrong");
    AST_DONE_READ: assert property (diag_run_o && diag_done_i ##1
        (bus_i.rd && bus_i.addr == CABLE_DIAG_CONTROL_OFS) |=>
        rdata_o[1] && rdata_o[0] == $past(diag_fail_i, 2))
        else $error("done or fail status wrong after measurement");
    AST_SW_RESET: assert property (wr_rst && bus_i.wdata[15] |->
        ##2 phy_reset_o ##1 !phy_reset_o)
        else $error("full reset pulse missing or too long");
    AST_RESTART: assert property (wr_rst && bus_i.wdata[14] && !bus_i.wdata[15] |->
        ##2 dig_restart_o ##1 !dig_restart_o)
        else $error("restart pulse missing or too long");
    AST_TEST_CFG: assert property (wr_test |=> test_en_o == $past(bus_i.wdata[4]) &&
        test_sel_o == $past(bus_i.wdata[3:0]))
        else $error("test pattern outputs do not follow write");
    AST_UNMAPPED_ZERO: assert property (bus_i.rd && !mapped |=> rdata_o == 16'h0000)
        else $error("unmapped read returned data");
    AST_STRAP_POL: assert property ($rose(rst_n_i) ##1 rd_led |=>
        rdata_o[LED_POL_BIT] == !$past(strap_pu_i, 2))
        else $error("LED polarity did not load from the strap");
    AST_UNROUTED_IDLE: assert property (wr_led ##1 !wr_led |=>
        (col_led_o == !$past(pol_w, 2) || $past(route_w, 2) == ROUTE_COL) &&
        (led0_o == !$past(pol_w, 2) || $past(route_w, 2) == ROUTE_LED0))
        else $error("unrouted LED pin not at its inactive level");
    cover property (diag_run_o && diag_done_i && diag_fail_i);
    cover property (phy_reset_o);
    cover property (dig_restart_o);
endmodule

bind pmc_regs pmc_regs_props props_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .strap_pu_i(strap_pu_i), .status_i(status_i), .diag_done_i(diag_done_i),
    .diag_fail_i(diag_fail_i), .diag_run_o(diag_run_o), .phy_reset_o(phy_reset_o),
    .dig_restart_o(dig_restart_o), .test_en_o(test_en_o), .test_sel_o(test_sel_o),
    .col_led_o(col_led_o), .led0_o(led0_o));
`default_nettype wire

// File: verif/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pmc_pkg::*;
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected %s expected %h seen %h", nm, exp, got); end end
    logic            mclk_i = 1'b0;
    logic            rst_n_i = 1'b0;
    pmc_bus_s        bus_i = '0;
    pmc_phy_status_s status_i = '0;
    pmc_phy_status_s st;
    logic            strap_pu_i = 1'b0;
    logic            diag_done_i = 1'b0;
    logic            diag_fail_i = 1'b0;
    logic [15:0]     rdata_o;
    logic [3:0]      test_sel_o;
    logic            diag_run_o, phy_reset_o, dig_restart_o, test_en_o, col_led_o, led0_o;
    logic            pol;
    logic [1:0]      route;
    logic [15:0]     v;
    logic [3:0]      code;
    int              err_total = 0;
    int              checks = 0;
    integer          seed = 32'h2d0b6bff;

    always #5 mclk_i = ~mclk_i;

    pmc_regs dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .strap_pu_i(strap_pu_i), .status_i(status_i), .diag_done_i(diag_done_i),
        .diag_fail_i(diag_fail_i), .diag_run_o(diag_run_o), .phy_reset_o(phy_reset_o),
        .dig_restart_o(dig_restart_o), .test_en_o(test_en_o), .test_sel_o(test_sel_o),
        .col_led_o(col_led_o), .led0_o(led0_o));

    // ------------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_i);
        bus_i.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge mclk_i);
        bus_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_i);
        bus_i.rd <= 1'b0;
        #1;
        `CHK("read data", e & m, rdata_o & m)
    endtask
    function automatic logic ind(input logic [3:0] c, input pmc_phy_status_s s);
        case (c)
            4'h0: ind = s.link_ok;
            4'h1: ind = s.tx_act | s.rx_act;
            4'h2: ind = s.tx_act;
            4'h3: ind = s.rx_act;
            4'h4: ind = s.collision;
            4'h5: ind = s.speed_100;
            4'h6: ind = !s.speed_100;
            4'h7: ind = s.full_duplex;
            4'h8: ind = s.link_ok & !((s.tx_act | s.rx_act) & s.blink);
            4'h9: ind = s.stretch_act;
            4'ha: ind = s.link_ok & s.speed_100 & s.full_duplex;
            4'hb: ind = s.lpi;
            4'hc: ind = s.mii_err;
            default: ind = 1'b0;
        endcase
    endfunction
    task automatic chk_led(input logic i);
        tick(2);
        #1;
        `CHK("collision pin", (route == 2'h0) ? (i ~^ pol) : !pol, col_led_o)
        `CHK("led0 pin", (route == 2'h3) ? (i ~^ pol) : !pol, led0_o)
    endtask
    task automatic set_link(input logic l);
        @(posedge mclk_i);
        status_i <= '{link_ok: l, default: 1'b0};
    endtask
    task automatic print_verdict();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge mclk_i);
        err_total++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        tick(12);
        rst_n_i <= 1'b1;
        rd(CABLE_DIAG_CONTROL_OFS, 16'h0102, 16'hffff);
        rd(PHY_RESET_CONTROL_OFS, 16'h0000, 16'hffff);
        rd(LED_FUNCTION_CONTROL_OFS, 16'h0200, 16'hffff);
        rd(COMPLIANCE_TEST_CONTROL_OFS, 16'h0000, 16'hffff);
        rd(8'h40, 16'h0000, 16'hffff);
        for (int n = 0; n < 52; n++) begin
            pol = 1'($random(seed));
            route = 2'($random(seed));
            code = 4'(n % 13);
            if (code == 4'hc && n % 2 == 1) begin
                code = 4'hf;
            end
            v = {6'h00, pol, 2'h0, code, 1'b0, route};
            wr(LED_FUNCTION_CONTROL_OFS, v);
            rd(LED_FUNCTION_CONTROL_OFS, v, 16'hffff);
            st = pmc_phy_status_s'(11'($random(seed)) & 11'h7fe);
            @(posedge mclk_i);
            status_i <= st;
            chk_led(ind(code, st));
        end
        pol = 1'b1;
        route = 2'h3;
        wr(LED_FUNCTION_CONTROL_OFS, 16'h026b);
        set_link(1'b1);
        rd(BASIC_MODE_OFS, 16'h0000, 16'hffff);
        chk_led(1'b0);
        set_link(1'b0);
        chk_led(1'b1);
        set_link(1'b1);
        chk_led(1'b1);
        rd(BASIC_MODE_OFS, 16'h0000, 16'hffff);
        chk_led(1'b0);
        wr(LED_FUNCTION_CONTROL_OFS, 16'h0273);
        wr(SELF_TEST_ONE_OFS, 16'h8000);
        chk_led(1'b0);
        @(posedge mclk_i);
        status_i.prbs_err <= 1'b1;
        @(posedge mclk_i);
        status_i.prbs_err <= 1'b0;
        chk_led(1'b1);
        wr(SELF_TEST_ONE_OFS, 16'h0000);
        chk_led(1'b1);
        wr(SELF_TEST_ONE_OFS, 16'h8000);
        chk_led(1'b0);
        for (int f = 1; f >= 0; f--) begin
            wr(CABLE_DIAG_CONTROL_OFS, 16'h8000);
            rd(CABLE_DIAG_CONTROL_OFS, 16'h8100, 16'hffff);
            `CHK("diag run", 1'b1, diag_run_o)
            @(posedge mclk_i);
            diag_done_i <= 1'b1;
            diag_fail_i <= 1'(f);
            @(posedge mclk_i);
            diag_done_i <= 1'b0;
            bus_i <= '{addr: CABLE_DIAG_CONTROL_OFS, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
            @(posedge mclk_i);
            bus_i.rd <= 1'b0;
            #1;
            `CHK("diag status", 16'h0102 | 16'(f), rdata_o)
            `CHK("diag run", 1'b0, diag_run_o)
        end
        wr(CABLE_DIAG_CONTROL_OFS, 16'h7fff);
        rd(CABLE_DIAG_CONTROL_OFS, 16'h0102, 16'hffff);
        wr(BASIC_MODE_OFS, 16'h0000);
        for (int n = 0; n < 8; n++) begin
            v = 16'($random(seed)) & 16'h001f;
            if (v[4] && v[3:0] inside {4'h3, 4'h4}) begin
                v[3:0] = 4'h9;
            end
            wr(COMPLIANCE_TEST_CONTROL_OFS, v);
            rd(COMPLIANCE_TEST_CONTROL_OFS, v, 16'hffff);
            `CHK("test enable", v[4], test_en_o)
            `CHK("test select", v[3:0], test_sel_o)
        end
        wr(PHY_RESET_CONTROL_OFS, 16'h4000);
        @(posedge mclk_i);
        #1;
        `CHK("restart pulse", 1'b1, dig_restart_o)
        rd(COMPLIANCE_TEST_CONTROL_OFS, v, 16'hffff);
        rd(PHY_RESET_CONTROL_OFS, 16'h0000, 16'hffff);
        wr(PHY_RESET_CONTROL_OFS, 16'h8000);
        @(posedge mclk_i);
        #1;
        `CHK("reset pulse", 1'b1, phy_reset_o)
        rd(COMPLIANCE_TEST_CONTROL_OFS, 16'h0000, 16'hffff);
        rd(LED_FUNCTION_CONTROL_OFS, 16'h0200, 16'hffff);
        rd(PHY_RESET_CONTROL_OFS, 16'h0000, 16'hffff);
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        strap_pu_i <= 1'b1;
        tick(3);
        rst_n_i <= 1'b1;
        rd(LED_FUNCTION_CONTROL_OFS, 16'h0000, 16'hffff);
        print_verdict();
    end
endmodule
`default_nettype wire
